// file: src/cal_link_if.sv
// control link between host and converter calibration sequencer
interface cal_link_if #(parameter int W = 24);
    logic                    mode_wr;
    cal_seq_pkg::cal_mode_t  mode;
    logic                    bipolar;
    logic                    result_rd;
    logic                    result_ready_n;
    logic [W-1:0]            result;
    logic                    result_stale;

    modport dev (
        input  mode_wr,
        input  mode,
        input  bipolar,
        input  result_rd,
        output result_ready_n,
        output result,
        output result_stale
    );
    modport host (
        output mode_wr,
        output mode,
        output bipolar,
        output result_rd,
        input  result_ready_n,
        input  result,
        input  result_stale
    );
endinterface

// file: src/cal_seq_consts.svh
// constants shared by both ends of the calibration mode sequencer
`ifndef CAL_SEQ_CONSTS_SVH
`define CAL_SEQ_CONSTS_SVH

// ****************************************
// mode field codes
// ****************************************
`define CAL_NORMAL     3'h0
`define CAL_SELF       3'h1
`define CAL_SYS_ZERO   3'h2
`define CAL_SYS_FULL   3'h3
`define CAL_SYS_OFS    3'h4
`define CAL_BACKGND    3'h5

// ****************************************
// control register reset values
// ****************************************
`define CTRL_MODE_RST  3'h0
`define CTRL_BIP_RST   1'b0

// ****************************************
// calibration timing in output periods
// ****************************************
`define DUR_ONE_STEP   4'h9
`define DUR_SYS_STEP   4'h4
`define ZERO_SLOT      4'h2
`define REF_SLOT       4'h4
`define BG_LAST_SLOT   3'h5

`endif

// file: src/cal_seq_device.sv
// converter end: control register, calibration sequencing and result correction
`include "cal_seq_consts.svh"
module cal_seq_device #(
    parameter int W       = 24,
    parameter int FR      = 16,
    parameter int OUT_DIV = 1000
) (
    input  wire logic                    clk_in,
    input  wire logic                    rst_in,
    cal_link_if.dev                      link,
    input  wire logic [W-1:0]            analog_input_in,
    input  wire logic [W-1:0]            shorted_node_in,
    input  wire logic [W-1:0]            ref_node_in,
    output cal_seq_pkg::cal_mode_t       mode_out,
    output wire logic                    cal_busy_out
);
    import cal_seq_pkg::*;

    localparam int GW = W + FR + 1;
    localparam int PW = W + GW + 3;
    localparam int DW = (OUT_DIV > 1) ? $clog2(OUT_DIV) : 1;
    localparam logic [DW-1:0] DIV_LAST = DW'(OUT_DIV - 1);

    // ****************************************
    // coefficient arithmetic
    // ****************************************
    // full-scale coefficient: target span over measured span, fixed point with FR fraction bits
    function automatic logic [GW-1:0] calc_gain(
        input logic [W-1:0] hi,
        input logic [W-1:0] lo,
        input logic         bip
    );
        logic [GW-1:0] target;
        logic [W:0]    span;
        target = bip ? (GW'(1) << (W - 1 + FR)) : (GW'(1) << (W + FR));
        span   = {1'b0, hi} - {1'b0, lo};
        // a zero span would divide by zero and a negative one wraps; fall back to unity slope
        if (hi <= lo)
            calc_gain = GW'(1) << FR;
        else
            calc_gain = target / GW'(span);
    endfunction

    // subtract offset first, then multiply by the full-scale coefficient
    function automatic logic [W-1:0] correct(
        input logic [W-1:0]  raw,
        input logic [W-1:0]  ofs,
        input logic [GW-1:0] gain,
        input logic          bip
    );
        logic signed [W+1:0]  diff;
        logic signed [PW-1:0] prod;
        logic signed [PW-1:0] val;
        diff = $signed({2'b00, raw}) - $signed({2'b00, ofs});
        prod = $signed(PW'(diff)) * $signed(PW'({1'b0, gain}));
        // bipolar zero point lands on midscale
        val  = (prod >>> FR) + (bip ? (PW'(1) << (W - 1)) : PW'(0));
        if (val < 0)
            correct = '0;
        else if (val > $signed(PW'({W{1'b1}})))
            correct = {W{1'b1}};
        else
            correct = val[W-1:0];
    endfunction

    // ****************************************
    // state
    // ****************************************
    logic [DW-1:0]  div_r;
    cal_mode_t      mode_r,   mode_nxt;
    logic           bip_r,    bip_nxt;
    dev_state_t     state_r,  state_nxt;
    logic [3:0]     per_r,    per_nxt;
    logic [2:0]     slot_r,   slot_nxt;
    logic [W-1:0]   ofs_r,    ofs_nxt;
    logic [GW-1:0]  gain_r,   gain_nxt;
    logic [W-1:0]   res_r,    res_nxt;
    logic           stale_r,  stale_nxt;
    logic           rdy_n_r,  rdy_n_nxt;
    logic           first_r,  first_nxt;

    // ****************************************
    // decode
    // ****************************************
    wire            per_tick   = (div_r == DIV_LAST);
    wire [3:0]      per_inc    = per_r + 4'h1;
    wire            is_self    = (mode_r == `CAL_SELF);
    wire            is_sys_ofs = (mode_r == `CAL_SYS_OFS);
    wire            is_zero    = (mode_r == `CAL_SYS_ZERO);
    wire            is_full    = (mode_r == `CAL_SYS_FULL);
    wire            one_step   = is_self || is_sys_ofs;
    wire [3:0]      cal_dur    = one_step ? `DUR_ONE_STEP : `DUR_SYS_STEP;
    wire            wr_cal     = (link.mode >= `CAL_SELF) && (link.mode <= `CAL_SYS_OFS);
    wire            wr_bg      = (link.mode == `CAL_BACKGND);
    wire [W-1:0]    zero_src   = is_self ? shorted_node_in : analog_input_in;
    wire [W-1:0]    conv_res   = correct(analog_input_in, ofs_r, gain_r, bip_r);

    assign link.result_ready_n = rdy_n_r;
    assign link.result         = res_r;
    assign link.result_stale   = stale_r;
    assign mode_out            = mode_r;
    assign cal_busy_out        = (state_r == ST_CAL);

    // ****************************************
    // sequencer
    // ****************************************
    always_comb
    begin
        mode_nxt  = mode_r;
        bip_nxt   = bip_r;
        state_nxt = state_r;
        per_nxt   = per_r;
        slot_nxt  = slot_r;
        ofs_nxt   = ofs_r;
        gain_nxt  = gain_r;
        res_nxt   = res_r;
        stale_nxt = stale_r;
        first_nxt = first_r;
        rdy_n_nxt = rdy_n_r;
        if (link.result_rd)
            rdy_n_nxt = 1'b1;
        if (link.mode_wr)
        begin
            // a new command restarts the filter and the period count
            mode_nxt  = link.mode;
            bip_nxt   = link.bipolar;
            per_nxt   = 4'h0;
            slot_nxt  = 3'h0;
            first_nxt = 1'b1;
            rdy_n_nxt = 1'b1;
            if (wr_cal)
                state_nxt = ST_CAL;
            else if (wr_bg)
                state_nxt = ST_BG;
            else
                state_nxt = ST_CONV;
        end
        else if (per_tick)
        begin
            case (state_r)
                ST_CONV:
                begin
                    res_nxt   = conv_res;
                    stale_nxt = 1'b0;
                    rdy_n_nxt = 1'b0;
                end
                ST_CAL:
                begin
                    per_nxt = per_inc;
                    if (per_inc == `ZERO_SLOT)
                    begin
                        if (is_full)
                            gain_nxt = calc_gain(analog_input_in, ofs_r, bip_r);
                        else
                            ofs_nxt = zero_src;
                    end
                    if ((per_inc == `REF_SLOT) && one_step)
                        gain_nxt = calc_gain(ref_node_in, ofs_r, bip_r);
                    if (per_inc == cal_dur)
                    begin
                        // completion: filter resettled on the input, first result ready
                        state_nxt = ST_CONV;
                        // coefficients land at earlier slots, so the registers already hold them
                        res_nxt   = conv_res;
                        stale_nxt = 1'b0;
                        rdy_n_nxt = 1'b0;
                    end
                end
                ST_BG:
                begin
                    // state only leaves through a new mode write
                    slot_nxt = (slot_r == `BG_LAST_SLOT) ? 3'h0 : slot_r + 3'h1;
                    if (slot_r == 3'h0)
                        ofs_nxt = shorted_node_in;
                    if (slot_r == `BG_LAST_SLOT)
                    begin
                        // reference conversion follows the output, so the first frame
                        // still uses the slope from before background mode
                        res_nxt   = conv_res;
                        stale_nxt = first_r;
                        first_nxt = 1'b0;
                        rdy_n_nxt = 1'b0;
                        gain_nxt  = calc_gain(ref_node_in, ofs_r, bip_r);
                    end
                end
                default:
                    state_nxt = ST_CONV;
            endcase
        end
    end

    always_ff @(posedge clk_in)
    begin
        if (rst_in)
        begin
            div_r   <= '0;
            mode_r  <= `CTRL_MODE_RST;
            bip_r   <= `CTRL_BIP_RST;
            state_r <= ST_CONV;
            per_r   <= 4'h0;
            slot_r  <= 3'h0;
            ofs_r   <= '0;
            gain_r  <= GW'(1) << FR;
            res_r   <= '0;
            stale_r <= 1'b0;
            rdy_n_r <= 1'b1;
            first_r <= 1'b0;
        end
        else
        begin
            div_r   <= (per_tick || link.mode_wr) ? '0 : div_r + DW'(1);
            mode_r  <= mode_nxt;
            bip_r   <= bip_nxt;
            state_r <= state_nxt;
            per_r   <= per_nxt;
            slot_r  <= slot_nxt;
            ofs_r   <= ofs_nxt;
            gain_r  <= gain_nxt;
            res_r   <= res_nxt;
            stale_r <= stale_nxt;
            rdy_n_r <= rdy_n_nxt;
            first_r <= first_nxt;
        end
    end
endmodule

// file: src/cal_seq_host.sv
// host end: issues mode writes, waits out calibration, reads results
`include "cal_seq_consts.svh"
module cal_seq_host #(
    parameter int W          = 24,
    parameter int BOOT_CYC   = 5000,
    parameter int MOD_CYC    = 64
) (
    input  wire logic                    clk_in,
    input  wire logic                    rst_in,
    cal_link_if.host                     link,
    input  wire logic                    cmd_valid_in,
    input  cal_seq_pkg::cal_mode_t       cmd_mode_in,
    input  wire logic                    cmd_bipolar_in,
    output wire logic                    cmd_ready_out,
    output logic                         cal_done_out,
    output logic [W-1:0]                 result_out,
    output logic                         result_stale_out,
    output logic                         result_valid_out
);
    import cal_seq_pkg::*;

    localparam int CW = $clog2(BOOT_CYC + MOD_CYC + 2);

    host_state_t    st_r,    st_nxt;
    logic [CW-1:0]  cnt_r,   cnt_nxt;
    logic           wr_r,    wr_nxt;
    cal_mode_t      mode_r,  mode_nxt;
    logic           bip_r,   bip_nxt;

    // ****************************************
    // decode
    // ****************************************
    wire            ready_seen = !link.result_ready_n;
    wire            take_cmd   = cmd_valid_in && (st_r == H_IDLE);
    wire            is_cal_cmd = (cmd_mode_in != `CAL_NORMAL) && (cmd_mode_in <= `CAL_BACKGND);
    wire            do_read    = ready_seen && ((st_r == H_IDLE) || (st_r == H_WAIT));

    assign link.mode_wr   = wr_r;
    assign link.mode      = mode_r;
    assign link.bipolar   = bip_r;
    assign link.result_rd = do_read;
    // user must keep the calibration input steady while this stays low
    assign cmd_ready_out  = (st_r == H_IDLE);

    // ****************************************
    // command sequencing
    // ****************************************
    always_comb
    begin
        st_nxt   = st_r;
        cnt_nxt  = cnt_r;
        wr_nxt   = 1'b0;
        mode_nxt = mode_r;
        bip_nxt  = bip_r;
        case (st_r)
            H_BOOT:
            begin
                // reference settling wait, then an automatic self-calibration
                cnt_nxt = cnt_r + CW'(1);
                if (cnt_r == CW'(BOOT_CYC - 1))
                begin
                    wr_nxt   = 1'b1;
                    mode_nxt = `CAL_SELF;
                    bip_nxt  = `CTRL_BIP_RST;
                    cnt_nxt  = '0;
                    st_nxt   = H_IGNORE;
                end
            end
            H_IDLE:
            begin
                if (take_cmd)
                begin
                    wr_nxt   = 1'b1;
                    mode_nxt = cmd_mode_in;
                    bip_nxt  = cmd_bipolar_in;
                    cnt_nxt  = '0;
                    st_nxt   = is_cal_cmd ? H_IGNORE : H_IDLE;
                end
            end
            H_IGNORE:
            begin
                // ready may lag the command by up to one modulator cycle
                cnt_nxt = cnt_r + CW'(1);
                if (cnt_r == CW'(MOD_CYC - 1))
                    st_nxt = H_WAIT;
            end
            H_WAIT:
            begin
                if (ready_seen)
                    st_nxt = H_IDLE;
            end
            default:
                st_nxt = H_IDLE;
        endcase
    end

    always_ff @(posedge clk_in)
    begin
        if (rst_in)
        begin
            st_r             <= H_BOOT;
            cnt_r            <= '0;
            wr_r             <= 1'b0;
            mode_r           <= `CTRL_MODE_RST;
            bip_r            <= `CTRL_BIP_RST;
            cal_done_out     <= 1'b0;
            result_out       <= '0;
            result_stale_out <= 1'b0;
            result_valid_out <= 1'b0;
        end
        else
        begin
            st_r             <= st_nxt;
            cnt_r            <= cnt_nxt;
            wr_r             <= wr_nxt;
            mode_r           <= mode_nxt;
            bip_r            <= bip_nxt;
            cal_done_out     <= ready_seen && (st_r == H_WAIT);
            result_valid_out <= do_read;
            if (do_read)
            begin
                result_out       <= link.result;
                result_stale_out <= link.result_stale;
            end
        end
    end
endmodule

// file: src/cal_seq_pkg.sv
// types shared by both ends of the calibration mode sequencer
package cal_seq_pkg;
    typedef logic [2:0] cal_mode_t;
    typedef enum logic [1:0] {ST_CONV, ST_CAL, ST_BG} dev_state_t;
    typedef enum logic [2:0] {H_BOOT, H_IDLE, H_IGNORE, H_WAIT} host_state_t;
endpackage

// file: verif/calibration_mode_sequencer_chk.sv
// assertions on the link between the host end and the converter end
module calibration_mode_sequencer_chk #(
    parameter int W       = 24,
    parameter int OUT_DIV = 4
) (
    input wire logic                   clk_in,
    input wire logic                   rst_in,
    input wire logic                   mode_wr,
    input wire cal_seq_pkg::cal_mode_t mode,
    input wire logic                   bipolar,
    input wire logic                   result_rd,
    input wire logic                   result_ready_n,
    input wire logic [W-1:0]           result,
    input wire logic                   result_stale
);
    import cal_seq_pkg::*;

    // ****************************************
    // cycles since the last mode write
    // ****************************************
    logic [15:0] cnt_r;
    logic [15:0] cnt_nxt;
    logic        first_r;
    cal_mode_t   wmode_r;

    assign cnt_nxt = (rst_in || mode_wr) ? 16'h0 : cnt_r + 16'h1;

    always_ff @(posedge clk_in)
    begin
        cnt_r <= cnt_nxt;
    end

    always_ff @(posedge clk_in)
    begin
        if (rst_in)
        begin
            first_r <= 1'b0;
            wmode_r <= 3'h7; // no write yet, so no timing is claimed
        end
        else if (mode_wr)
        begin
            first_r <= 1'b1;
            wmode_r <= mode;
        end
        else if (!result_ready_n)
        begin
            first_r <= 1'b0;
        end
    end

    // ****************************************
    // link assertions
    // ****************************************
    AST_WR_READY_HIGH: assert property (@(posedge clk_in) disable iff (rst_in)
        mode_wr |=> result_ready_n)
        else $error("ready still low after a mode write");
    AST_SELF_TIME: assert property (@(posedge clk_in) disable iff (rst_in)
        $fell(result_ready_n) && first_r && (wmode_r == 3'h1 || wmode_r == 3'h4)
        |-> cnt_r == 9 * OUT_DIV)
        else $error("one-step calibration length wrong");
    AST_SYS_TIME: assert property (@(posedge clk_in) disable iff (rst_in)
        $fell(result_ready_n) && first_r && (wmode_r == 3'h2 || wmode_r == 3'h3)
        |-> cnt_r == 4 * OUT_DIV)
        else $error("system calibration step length wrong");
    AST_BG_FIRST: assert property (@(posedge clk_in) disable iff (rst_in)
        $fell(result_ready_n) && first_r && wmode_r == 3'h5
        |-> cnt_r == 6 * OUT_DIV && result_stale)
        else $error("first background result late or not flagged");
    AST_BG_RATE: assert property (@(posedge clk_in) disable iff (rst_in)
        $fell(result_ready_n) && !first_r && wmode_r == 3'h5
        |-> (cnt_r % (6 * OUT_DIV)) == 0 && !result_stale)
        else $error("background result rate wrong");
    AST_NORMAL_RATE: assert property (@(posedge clk_in) disable iff (rst_in)
        $fell(result_ready_n) && wmode_r == 3'h0 |-> (cnt_r % OUT_DIV) == 0)
        else $error("normal result rate wrong");
    AST_READ_CLEAR: assert property (@(posedge clk_in) disable iff (rst_in)
        result_rd && !result_ready_n && !mode_wr && (cnt_r % OUT_DIV) != OUT_DIV - 1
        |=> result_ready_n)
        else $error("ready not released by a read");
    AST_STALE_ONLY_BG: assert property (@(posedge clk_in) disable iff (rst_in)
        $rose(result_stale) |-> wmode_r == 3'h5 && $past(wmode_r) == 3'h5)
        else $error("stale flag outside background mode");
    AST_WR_NO_READ: assert property (@(posedge clk_in) disable iff (rst_in)
        mode_wr && mode >= 3'h1 && mode <= 3'h5 |-> !result_rd ##1 !result_rd)
        else $error("host read ready inside the ignore window");
    AST_RESET_VALUES: assert property (@(posedge clk_in)
        rst_in |=> result_ready_n && result == '0 && !result_stale)
        else $error("link outputs not at reset values");
endmodule

// file: verif/calibration_mode_sequencer_test.sv
// self-checking bench for both ends of the calibration mode sequencer
module calibration_mode_sequencer_test;
    timeunit 1ns;
    timeprecision 1ps;
    import cal_seq_pkg::*;

    // ****************************************
    // stimulus and observation
    // ****************************************
    localparam int W     = 24;
    localparam int D     = 4;    // short output period keeps the run brief
    localparam int LIMIT = 2000;
    logic         clk_in;
    logic         rst_in;
    logic         cmd_valid_in;
    logic         cmd_bipolar_in;
    cal_mode_t    cmd_mode_in;
    logic [W-1:0] analog_input;
    logic [W-1:0] shorted_node;
    logic [W-1:0] ref_node;
    cal_mode_t    dev_mode;
    logic         cal_busy;
    logic         cmd_ready;
    logic         cal_done;
    logic [W-1:0] result_v;
    logic         stale;
    logic         valid;
    int           errors = 0;
    int           cmp_count = 0;
    int           cycles = 0;

    cal_link_if #(.W(W)) link ();

    cal_seq_device #(.W(W), .FR(16), .OUT_DIV(D)) i_cal_seq_device (
        .clk_in          (clk_in),
        .rst_in          (rst_in),
        .link            (link),
        .analog_input_in (analog_input),
        .shorted_node_in (shorted_node),
        .ref_node_in     (ref_node),
        .mode_out        (dev_mode),
        .cal_busy_out    (cal_busy)
    );

    cal_seq_host #(.W(W), .BOOT_CYC(10), .MOD_CYC(2)) i_cal_seq_host (
        .clk_in           (clk_in),
        .rst_in           (rst_in),
        .link             (link),
        .cmd_valid_in     (cmd_valid_in),
        .cmd_mode_in      (cmd_mode_in),
        .cmd_bipolar_in   (cmd_bipolar_in),
        .cmd_ready_out    (cmd_ready),
        .cal_done_out     (cal_done),
        .result_out       (result_v),
        .result_stale_out (stale),
        .result_valid_out (valid)
    );

    calibration_mode_sequencer_chk #(.W(W), .OUT_DIV(D)) i_calibration_mode_sequencer_chk (
        .clk_in         (clk_in),
        .rst_in         (rst_in),
        .mode_wr        (link.mode_wr),
        .mode           (link.mode),
        .bipolar        (link.bipolar),
        .result_rd      (link.result_rd),
        .result_ready_n (link.result_ready_n),
        .result         (link.result),
        .result_stale   (link.result_stale)
    );

    initial
    begin
        clk_in = 1'b0;
        forever #2.5 clk_in = ~clk_in;
    end

    // ****************************************
    // shared tasks
    // ****************************************
    task automatic chk_val(input string n, input logic [W-1:0] e, input logic [W-1:0] g);
        cmp_count++;
        if (g !== e)
        begin
            errors++;
            $display("wrong value %s expected %h seen %h", n, e, g);
        end
    endtask

    task automatic chk_cnt(input string n, input int e, input int g);
        cmp_count++;
        if (g != e)
        begin
            errors++;
            $display("wrong value %s expected %0d seen %0d", n, e, g);
        end
    endtask

    task automatic wrap_up();
        $display("comparisons %0d errors %0d", cmp_count, errors);
        if (errors == 0 && cmp_count > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    // waits for a calibration end or a plain result; t counts the cycles waited
    task automatic wait_for(input logic want_done, output logic [W-1:0] r, output logic s,
                            output int t);
        t = 0;
        do
        begin
            @(posedge clk_in);
            #1;
            t++;
        end
        while ((want_done ? cal_done : valid) !== 1'b1);
        r = result_v;
        s = stale;
    endtask

    task automatic issue(input cal_mode_t m, input logic b);
        while (cmd_ready !== 1'b1)
        begin
            @(posedge clk_in);
            #1;
        end
        cmd_mode_in = m;
        cmd_bipolar_in = b;
        cmd_valid_in = 1'b1;
        @(posedge clk_in);
        #1;
        cmd_valid_in = 1'b0;
    endtask

    task automatic cal(input cal_mode_t m, input logic b);
        logic [W-1:0] r;
        logic         s;
        int           t;
        int           n;
        n = (m == 3'h1 || m == 3'h4) ? 9 : 4;
        issue(m, b);
        @(posedge clk_in);
        #1;
        chk_val("busy during calibration", W'(1'b1), W'(cal_busy));
        wait_for(1'b1, r, s, t);
        chk_cnt("calibration cycles", n * D + 1, t);
        chk_val("busy after calibration", W'(1'b0), W'(cal_busy));
    endtask

    // the first result after the write may still belong to the old mode
    task automatic read_norm(input logic b, input logic [W-1:0] e);
        logic [W-1:0] r;
        logic         s;
        int           t;
        issue(3'h0, b);
        repeat (3) wait_for(1'b0, r, s, t);
        chk_val("corrected result", e, r);
        chk_cnt("normal result interval", D, t);
    endtask

    // ****************************************
    // scenarios
    // ****************************************
    task automatic s_self();
        logic [W-1:0] r;
        logic         s;
        int           t;
        chk_val("mode after reset", W'(3'h0), W'(dev_mode));
        wait_for(1'b1, r, s, t);
        chk_cnt("boot calibration cycles", 10 + 9 * D + 2, t);
        read_norm(1'b0, 24'h400000);
    endtask

    task automatic s_two_step();
        analog_input = 24'h200000;
        cal(3'h2, 1'b0);
        analog_input = 24'h600000;
        cal(3'h3, 1'b0);
        analog_input = 24'h280000;
        read_norm(1'b0, 24'h200000);
    endtask

    task automatic s_zero_only();
        analog_input = 24'h300000;
        cal(3'h2, 1'b0);
        analog_input = 24'h380000;
        read_norm(1'b0, 24'h200000);
    endtask

    task automatic s_bipolar();
        analog_input = 24'h200000;
        cal(3'h2, 1'b1);
        analog_input = 24'h600000;
        cal(3'h3, 1'b1);
        analog_input = 24'h300000;
        read_norm(1'b1, 24'hA00000);
    endtask

    task automatic s_sys_offset();
        analog_input = 24'h100000;
        ref_node = 24'h500000;
        cal(3'h4, 1'b0);
        analog_input = 24'h140000;
        read_norm(1'b0, 24'h100000);
    endtask

    task automatic s_background();
        logic [W-1:0] r;
        logic         s;
        int           t;
        ref_node = 24'h900000;
        analog_input = 24'h180000;
        issue(3'h5, 1'b0);
        wait_for(1'b1, r, s, t);
        chk_val("first background result", 24'h200000, r);
        chk_val("first background stale", W'(1'b1), W'(s));
        wait_for(1'b0, r, s, t);
        chk_val("second background result", 24'h100000, r);
        chk_val("second background stale", W'(1'b0), W'(s));
        chk_cnt("background interval", 6 * D, t);
        chk_val("mode kept", W'(3'h5), W'(dev_mode));
        read_norm(1'b0, 24'h100000);
    endtask

    // ****************************************
    // main sequence and hang guard
    // ****************************************
    always @(posedge clk_in)
    begin
        cycles++;
        if (cycles == LIMIT)
        begin
            errors++;
            wrap_up();
        end
    end

    initial
    begin
        rst_in = 1'b1;
        cmd_valid_in = 1'b0;
        cmd_mode_in = 3'h0;
        cmd_bipolar_in = 1'b0;
        analog_input = 24'h300000;
        shorted_node = 24'h100000;
        ref_node = 24'h900000;
        repeat (6) @(posedge clk_in);
        #1;
        rst_in = 1'b0;
        s_self();
        s_two_step();
        s_zero_only();
        s_bipolar();
        s_sys_offset();
        s_background();
        wrap_up();
    end
endmodule
